// [design/dcl_link.sv]
// Cascaded serial command link: frame receiver, chain forwarding,
// synchronized frame sync and power-save control.
// Assumes the link clock and data arrive asynchronously and are
// oversampled by core_clk (40 MHz) at least four times per link edge.
// Summary of operation
// [RULE1] Controller idles data line high
// [RULE2] Controller runs link clock continuously
// [RULE3] High-to-low data transition starts frame
// [RULE4] Header is 16 bits plus check
// [RULE5] Per-device group: three 17-bit words
// [RULE6] Eighteen ones end frame, back idle
// [RULE7] Check bit inverts last data bit
// [RULE8] New start accepted right after end
// [RULE9] Data sampled on both clock edges
// [RULE10] Up to 32 devices, addresses 0..0x1F
// [RULE11] Chip index: adopt, increment, forward
// [RULE12] Command id selects broadcast or addressed
// [RULE13] Frame sync fires together chain-wide
// [RULE14] Delay sync by length minus address
// [RULE15] Controller sends sync to first device
// [RULE16] Zero data plus matrix command: off
// [RULE17] Matrix save exit needs command too
// [RULE18] Zero next frame: save at sync
// [RULE19] Non-zero data leaves save at once
// [RULE20] Supply lockout resets all registers; the group storage mem_reg in dcl_buf has no reset
// [RULE21] Fault indications force channels off
// [RULE22] Serial output forwards and returns data
// [RULE23] Addressed write keeps last 51 bits
// [RULE24] Read inserts own 48-bit word
// [RULE25] Words travel most significant bit first
// [RULE26] Unknown command ignored but forwarded
// [RULE27] Check mismatch flagged, word not committed
`timescale 1ns/1ps
`default_nettype none
`include "dcl_map.svh"
module dcl_link import dcl_pkg::*; (
    // Clock and reset (reset_n driven by supply lockout)
    input wire logic core_clk,
    input wire logic reset_n,
    // Serial link
    input wire logic serial_link_clk,
    input wire logic serial_data_input,
    output logic serial_data_output,
    // Fault indications
    input wire logic overtemp_entry_condition,
    input wire logic ref_short_entry_condition,
    // Received data groups
    output logic group_valid,
    input wire logic group_ready,
    output dcl_group_t group_data,
    // Status
    output logic frame_sync_pulse,
    output dcl_mode_t mode_status,
    output logic [4:0] chip_address,
    output logic framing_error,
    output logic group_overflow
);
    // ==========================================================
    // Input synchronisers
    logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
    logic sin_s1_reg, sin_s2_reg;
    logic ot_s1_reg, ot_s2_reg, rs_s1_reg, rs_s2_reg;
    logic link_edge;
    logic bit_in;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            clk_s3_reg <= 1'b0;
            sin_s1_reg <= 1'b1;
            sin_s2_reg <= 1'b1;
            ot_s1_reg <= 1'b0;
            ot_s2_reg <= 1'b0;
            rs_s1_reg <= 1'b0;
            rs_s2_reg <= 1'b0;
        end else begin
            clk_s1_reg <= serial_link_clk;
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            sin_s1_reg <= serial_data_input;
            sin_s2_reg <= sin_s1_reg;
            ot_s1_reg <= overtemp_entry_condition;
            ot_s2_reg <= ot_s1_reg;
            rs_s1_reg <= ref_short_entry_condition;
            rs_s2_reg <= rs_s1_reg;
        end
    end

    // Either link clock edge takes one bit
    assign link_edge = clk_s2_reg ^ clk_s3_reg; // RULE9
    assign bit_in = sin_s2_reg;

    // ==========================================================
    // Frame receiver
    dcl_state_t state_reg;
    logic [4:0] bit_cnt_reg;
    logic [4:0] ones_cnt_reg;
    logic [15:0] shift_reg;
    logic [16:0] cur_word;
    logic [15:0] cur_data;
    logic [7:0] cur_id;
    logic chk_ok;
    logic end_det;
    logic word_end;
    logic run_word;

    assign cur_word = {shift_reg, bit_in}; // RULE25
    assign cur_data = cur_word[16:1];
    assign cur_id = cur_data[`DCL_ID_HI:`DCL_ID_LO];
    assign chk_ok = (cur_word[0] == ~cur_word[1]); // RULE7
    // End run counted from a word boundary, so the group lines up in the
    // forwarding line whatever the last check bit was
    assign end_det = link_edge && (state_reg != DCL_IDLE) && bit_in
        && (ones_cnt_reg >= `DCL_RUN_END) && (bit_cnt_reg == 5'h00); // RULE6
    // Seventeen ones are the end run crossing a word boundary, not a word
    assign run_word = &cur_word;
    assign word_end = link_edge && (state_reg != DCL_IDLE) && !end_det
        && (bit_cnt_reg == `DCL_BIT_LAST); // RULE4 RULE5

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ones_cnt_reg <= 5'h00;
            shift_reg <= 16'h0000;
        end else if (link_edge) begin
            shift_reg <= cur_word[15:0];
            if (!bit_in) begin
                ones_cnt_reg <= 5'h00;
            end else if (ones_cnt_reg != `DCL_RUN_MAX) begin
                ones_cnt_reg <= ones_cnt_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= DCL_IDLE;
            bit_cnt_reg <= 5'h00;
        end else if (link_edge) begin
            case (state_reg)
                DCL_IDLE: begin
                    // A run of ones, even an end run, may be followed at once
                    if (!bit_in && ones_cnt_reg != 5'h00) begin // RULE3 RULE8
                        state_reg <= DCL_HEAD;
                        bit_cnt_reg <= 5'h00;
                    end
                end
                DCL_HEAD, DCL_DATA: begin
                    if (end_det) begin
                        state_reg <= DCL_IDLE; // RULE6
                    end else if (word_end) begin
                        state_reg <= DCL_DATA;
                        bit_cnt_reg <= 5'h00;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                default: begin
                    state_reg <= DCL_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Header and data capture
    logic [7:0] head_id_reg;
    logic head_ok_reg;
    logic [47:0] hist_reg;
    logic [2:0] hist_ok_reg;
    logic [1:0] nwords_reg;
    logic err_reg;
    logic hdr_ok;
    logic known_id;

    always_comb begin
        case (cur_id)
            `DCL_ID_CHIP_INDEX, `DCL_ID_VSYNC, `DCL_ID_MATRIX_POWER_SAVE_COMMAND, `DCL_ID_SOFT_RESET,
            `DCL_ID_WR_BCAST, `DCL_ID_WR_GS, `DCL_ID_WR_CHAIN,
            `DCL_ID_READ: known_id = 1'b1; // RULE12
            default: known_id = 1'b0; // RULE26
        endcase
    end

    // Unknown ids and bad headers act on nothing; forwarding is unaffected
    assign hdr_ok = word_end && (state_reg == DCL_HEAD) && chk_ok && known_id; // RULE26 RULE27

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            head_id_reg <= 8'h00;
            head_ok_reg <= 1'b0;
            hist_reg <= 48'h000000000000;
            hist_ok_reg <= 3'h0;
            nwords_reg <= 2'h0;
            err_reg <= 1'b0;
        end else begin
            err_reg <= word_end && !chk_ok && !run_word; // RULE27
            if (word_end && state_reg == DCL_HEAD) begin
                head_id_reg <= cur_id;
                head_ok_reg <= hdr_ok;
                nwords_reg <= 2'h0;
            end else if (word_end && !run_word) begin
                hist_reg <= {hist_reg[`DCL_HIST_KEEP:0], cur_data}; // RULE5
                hist_ok_reg <= {hist_ok_reg[1:0], chk_ok};
                if (nwords_reg != 2'h3) begin
                    nwords_reg <= nwords_reg + 2'h1;
                end
            end
        end
    end

    assign framing_error = err_reg;

    // ==========================================================
    // Command actions
    logic [4:0] addr_reg;
    logic [5:0] chain_len_reg;
    logic hdr_chip, hdr_vsync, hdr_matrix_power_save_command, hdr_soft;
    logic grp_ok, end_gs, end_bcast, end_chain, end_read;

    assign hdr_chip = hdr_ok && (cur_id == `DCL_ID_CHIP_INDEX);
    assign hdr_vsync = hdr_ok && (cur_id == `DCL_ID_VSYNC);
    assign hdr_matrix_power_save_command = hdr_ok && (cur_id == `DCL_ID_MATRIX_POWER_SAVE_COMMAND);
    assign hdr_soft = hdr_ok && (cur_id == `DCL_ID_SOFT_RESET);
    // A group is used only when all three words passed their check
    assign grp_ok = end_det && head_ok_reg && (nwords_reg == 2'h3) && (&hist_ok_reg); // RULE27
    assign end_gs = grp_ok && (head_id_reg == `DCL_ID_WR_GS);
    assign end_bcast = grp_ok && (head_id_reg == `DCL_ID_WR_BCAST);
    assign end_chain = grp_ok && (head_id_reg == `DCL_ID_WR_CHAIN);
    assign end_read = end_det && head_ok_reg && (head_id_reg == `DCL_ID_READ);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_reg <= `DCL_RST_ADDR; // RULE20
        end else if (hdr_chip) begin
            addr_reg <= cur_data[`DCL_IDX_HI:0]; // RULE10 RULE11
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            chain_len_reg <= `DCL_RST_CHAIN;
        end else if (hdr_soft) begin
            chain_len_reg <= `DCL_RST_CHAIN;
        end else if (end_chain) begin
            chain_len_reg <= hist_reg[`DCL_LEN_HI:0]; // RULE14
        end
    end

    assign chip_address = addr_reg;

    // ==========================================================
    // Forwarding line to the next device
    logic [`DCL_LINE_TOP:0] line_reg;
    logic [`DCL_GRP_TOP:0] inj_reg;
    logic [6:0] inj_cnt_reg;
    logic [`DCL_GRP_TOP:0] own_bits;
    logic [16:0] chip_fwd;

    assign chip_fwd = dcl_frame_word({cur_id, 3'h0, cur_data[`DCL_IDX_HI:0] + 5'h01});
    assign own_bits = {dcl_frame_word(`DCL_WORD_W'(addr_reg)),
        dcl_frame_word(`DCL_WORD_W'(chain_len_reg)),
        dcl_frame_word(`DCL_WORD_W'(mode_status))};

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            line_reg <= '1;
            inj_reg <= '1;
            inj_cnt_reg <= 7'h00;
        end else if (link_edge) begin
            if (end_read) begin
                // Own group goes ahead of the end run; the rest is fed in
                line_reg <= {line_reg[`DCL_LINE_NEXT:`DCL_LINE_DROP],
                    own_bits[`DCL_GRP_TOP:`DCL_OWN_CUT]}; // RULE24
                inj_reg <= {own_bits[`DCL_OWN_CUT-1:0], {`DCL_RUN_MAX{1'b1}}};
                inj_cnt_reg <= `DCL_GROUP_BITS;
            end else if (end_gs) begin
                line_reg <= '1; // RULE23
            end else if (hdr_chip) begin
                line_reg <= {line_reg[`DCL_LINE_NEXT:`DCL_HDR_KEEP], chip_fwd}; // RULE11
            end else if (inj_cnt_reg != 7'h00) begin
                // Limitation: upstream bits arriving during insertion are not passed on
                line_reg <= {line_reg[`DCL_LINE_NEXT:0], inj_reg[`DCL_GRP_TOP]};
                inj_reg <= {inj_reg[`DCL_GRP_TOP-1:0], 1'b1};
                inj_cnt_reg <= inj_cnt_reg - 7'h01;
            end else begin
                line_reg <= {line_reg[`DCL_LINE_NEXT:0], bit_in};
            end
        end
    end

    assign serial_data_output = line_reg[`DCL_LINE_TOP]; // RULE22 RULE25

    // ==========================================================
    // Synchronized frame sync
    logic vs_pend_reg;
    logic [11:0] vs_cnt_reg;
    logic [5:0] vs_diff;
    logic [11:0] vs_delay;
    logic sync_reg;

    // Each hop adds one forwarding line of delay
    assign vs_diff = chain_len_reg - {1'b0, addr_reg};
    assign vs_delay = (vs_diff == 6'h00) ? `DCL_LINE_LEN : 12'(vs_diff) * `DCL_LINE_LEN;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            vs_pend_reg <= 1'b0;
            vs_cnt_reg <= 12'h000;
            sync_reg <= 1'b0;
        end else begin
            sync_reg <= 1'b0;
            if (hdr_vsync) begin
                vs_pend_reg <= 1'b1; // RULE13
                vs_cnt_reg <= vs_delay; // RULE14
            end else if (vs_pend_reg && link_edge) begin
                if (vs_cnt_reg == 12'h001) begin
                    vs_pend_reg <= 1'b0;
                    sync_reg <= 1'b1;
                end else begin
                    vs_cnt_reg <= vs_cnt_reg - 12'h001;
                end
            end
        end
    end

    assign frame_sync_pulse = sync_reg;

    // ==========================================================
    // Power save and channel shutdown
    logic zero_reg, nz_frame_reg, matrix_power_save_command_reg, ps_reg, mps_reg, off_reg;
    logic nz_evt;

    assign nz_evt = end_gs && (hist_reg != 48'h000000000000);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            zero_reg <= 1'b0;
            nz_frame_reg <= 1'b0;
            matrix_power_save_command_reg <= 1'b0;
        end else if (sync_reg || hdr_soft) begin
            zero_reg <= !hdr_soft;
            nz_frame_reg <= 1'b0;
            matrix_power_save_command_reg <= 1'b0;
        end else begin
            if (nz_evt) begin
                zero_reg <= 1'b0;
                nz_frame_reg <= 1'b1;
            end
            if (hdr_matrix_power_save_command) begin
                matrix_power_save_command_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ps_reg <= 1'b0;
        end else if (nz_evt || hdr_soft) begin
            ps_reg <= 1'b0; // RULE19
        end else if (sync_reg && zero_reg) begin
            ps_reg <= 1'b1; // RULE18
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mps_reg <= 1'b0;
        end else if (hdr_soft || ((nz_evt || nz_frame_reg) && (hdr_matrix_power_save_command || matrix_power_save_command_reg))) begin
            mps_reg <= 1'b0; // RULE17
        end else if (sync_reg && zero_reg && matrix_power_save_command_reg) begin
            mps_reg <= 1'b1; // RULE16
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            off_reg <= 1'b0;
        end else begin
            off_reg <= ps_reg || mps_reg || ot_s2_reg || rs_s2_reg; // RULE18 RULE21
        end
    end

    assign mode_status = '{outputs_off: off_reg, power_save: ps_reg, matrix_save: mps_reg};

    // ==========================================================
    // Data groups to the user side
    logic push_ready;
    logic push_valid;
    logic ovf_reg;

    assign push_valid = end_gs || end_bcast; // RULE12 RULE23

    dcl_buf u_buf (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data('{cmd_id: head_id_reg, data: hist_reg}),
        .out_valid(group_valid),
        .out_ready(group_ready),
        .out_data(group_data)
    );

    // The link cannot stall, so a third unread group is reported
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ovf_reg <= 1'b0;
        end else begin
            ovf_reg <= push_valid && !push_ready;
        end
    end

    assign group_overflow = ovf_reg;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_start_bit;
        link_edge && state_reg == DCL_IDLE && !bit_in && ones_cnt_reg != 5'h00;
    endsequence
    sequence s_enter_head;
        state_reg == DCL_HEAD && bit_cnt_reg == 5'h00;
    endsequence

    start_detect_a: assert property (s_start_bit |=> s_enter_head) // RULE3
        else $error("start bit not taken");
    end_detect_a: assert property (end_det |=> state_reg == DCL_IDLE) // RULE6
        else $error("end run did not return to idle");
    head_length_a: assert property (
        state_reg == DCL_HEAD && link_edge && bit_cnt_reg == `DCL_BIT_LAST && !end_det
        |=> state_reg == DCL_DATA) // RULE4
        else $error("header length wrong");
    check_error_a: assert property (word_end && !chk_ok && !run_word |=> framing_error) // RULE27
        else $error("check mismatch not flagged");
    gs_drop_a: assert property (end_gs |=> &line_reg) // RULE23
        else $error("own group not dropped");
    chip_index_a: assert property (hdr_chip |=> chip_address == $past(cur_data[4:0])
        && line_reg[16:0] == $past(chip_fwd)) // RULE11
        else $error("chip index not adopted and forwarded");
    read_insert_a: assert property (end_read |=> inj_cnt_reg == `DCL_GROUP_BITS
        && line_reg[17:0] == $past(own_bits[50:33])) // RULE24
        else $error("readback not inserted");
    sync_fire_a: assert property (vs_pend_reg && link_edge && vs_cnt_reg == 12'h001
        && !hdr_vsync |=> frame_sync_pulse ##1 !frame_sync_pulse) // RULE14
        else $error("frame sync not fired on count");
    ps_exit_a: assert property (nz_evt |=> !mode_status.power_save) // RULE19
        else $error("power save not left on data");
    fault_off_a: assert property ((ot_s2_reg || rs_s2_reg) [*2] |-> mode_status.outputs_off) // RULE21
        else $error("fault did not turn outputs off");
endmodule : dcl_link
`default_nettype wire

// [design/dcl_map.svh]
// Named offsets, field positions, reset values and command codes of the
// cascaded serial command link. Definitions only; no logic.
`ifndef DCL_MAP_SVH
`define DCL_MAP_SVH

// Word and frame framing
`define DCL_WORD_W 16
`define DCL_BIT_LAST 5'h10
`define DCL_RUN_END 5'h11
`define DCL_RUN_MAX 5'h12
`define DCL_GROUP_BITS 7'h33
`define DCL_GRP_TOP 50
`define DCL_OWN_CUT 33
`define DCL_HIST_KEEP 31
// Forwarding line: one group plus the end run
`define DCL_LINE_TOP 68
`define DCL_LINE_NEXT 67
`define DCL_LINE_DROP 17
`define DCL_HDR_KEEP 16
`define DCL_LINE_LEN 12'h045
// Header fields: command id in the upper byte, chip index low
`define DCL_ID_HI 15
`define DCL_ID_LO 8
`define DCL_IDX_HI 4
`define DCL_LEN_HI 5
// Command identifiers (values are arbitrary)
`define DCL_ID_CHIP_INDEX 8'hA0
`define DCL_ID_VSYNC 8'hA1
`define DCL_ID_MATRIX_POWER_SAVE_COMMAND 8'hA2
`define DCL_ID_SOFT_RESET 8'hA3
`define DCL_ID_WR_BCAST 8'hA4
`define DCL_ID_WR_GS 8'hA5
`define DCL_ID_WR_CHAIN 8'hA6
`define DCL_ID_READ 8'hA7
// Reset values
`define DCL_RST_ADDR 5'h00
`define DCL_RST_CHAIN 6'h01

`endif

// [design/dcl_pkg.sv]
// Types shared by the serial command link and its data buffer.
// Assumes dcl_map.svh supplies the numeric constants.
package dcl_pkg;
    typedef enum logic [1:0] {
        DCL_IDLE = 2'b00,
        DCL_HEAD = 2'b01,
        DCL_DATA = 2'b10
    } dcl_state_t;

    typedef struct packed {
        logic [7:0] cmd_id;
        logic [47:0] data;
    } dcl_group_t;

    typedef struct packed {
        logic outputs_off;
        logic power_save;
        logic matrix_save;
    } dcl_mode_t;

    // Check bit is the inverse of the last data bit sent
    function automatic logic [16:0] dcl_frame_word(input logic [15:0] d);
        return {d, ~d[0]};
    endfunction : dcl_frame_word
endpackage : dcl_pkg

// [design/dcl_buf.sv]
// Two-entry buffer for received data groups, valid/ready on both sides.
// Assumes one clock domain with the link receiver.
`timescale 1ns/1ps
`default_nettype none
module dcl_buf import dcl_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire dcl_group_t in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output dcl_group_t out_data
);
    dcl_group_t mem_reg [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end
endmodule : dcl_buf
`default_nettype wire

// [testbench/dcl_ctl_model.sv]
// Display controller model driving the first device of the chain.
// Assumes the bench reads edge_cnt and hdr_edge hierarchically.
`timescale 1ns/1ps
`default_nettype none
module dcl_ctl_model (
    // Link toward the first device
    output var logic serial_link_clk,
    output var logic serial_data_input
);
    // ==========================================
    // Link clock and bit timing
    int edge_cnt = 0;
    int hdr_edge = 0;
    initial begin
        serial_link_clk = 1'b0;
        serial_data_input = 1'b1;
    end
    // Runs free, one edge every 100 ns
    always #100 serial_link_clk = ~serial_link_clk;
    always @(serial_link_clk) edge_cnt++;
    // Data moves midway between edges so both edges see it stable
    task automatic put_bit(input logic b);
        @(serial_link_clk);
        #50 serial_data_input = b;
    endtask : put_bit
    task automatic put_word(input logic [15:0] w, input logic bad);
        for (int i = 15; i >= 0; i--) put_bit(w[i]);
        put_bit(~w[0] ^ bad);
    endtask : put_word
    // ==========================================
    // Frames; bad spoils the check bit of the last word
    task automatic send_frame(input logic [15:0] hdr, input int nw,
                              input logic [47:0] d, input logic bad);
        put_bit(1'b0);
        put_word(hdr, 1'b0);
        hdr_edge = edge_cnt + 1;
        for (int k = 0; k < nw; k++) begin
            put_word(d[47 - 16 * k -: 16], bad && k == nw - 1);
        end
        repeat (18) put_bit(1'b1);
    endtask : send_frame
endmodule : dcl_ctl_model
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the serial command link.
// Assumes the controller model drives the link side.
`timescale 1ns/1ps
`default_nettype none
`include "dcl_map.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench import dcl_pkg::*; ;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic sclk, sdi, sdo, hot = 1'b0, rshort = 1'b0, gv, gr = 1'b0;
    logic fsp, ferr, govf;
    logic [4:0] addr;
    logic [16:0] out_sr = '1, target = '0;
    int n_hit = 0;
    dcl_group_t gd;
    dcl_mode_t mode;
    int num_errors = 0, n_tests = 0, n_ferr = 0, n_ovf = 0, sync_edge = -1;
    always #12.5 core_clk = ~core_clk;
    dcl_ctl_model ctl_i (.serial_link_clk(sclk), .serial_data_input(sdi));
    dcl_link dcl_link_i (.core_clk(core_clk), .reset_n(reset_n),
        .serial_link_clk(sclk), .serial_data_input(sdi),
        .serial_data_output(sdo), .overtemp_entry_condition(hot),
        .ref_short_entry_condition(rshort), .group_valid(gv),
        .group_ready(gr), .group_data(gd), .frame_sync_pulse(fsp),
        .mode_status(mode), .chip_address(addr), .framing_error(ferr),
        .group_overflow(govf));
    // ==========================================
    // Monitors
    always @(negedge core_clk) begin
        if (ferr === 1'b1) n_ferr++;
        if (govf === 1'b1) n_ovf++;
        if (fsp === 1'b1) sync_edge = ctl_i.edge_cnt;
    end
    // Output bit is settled half a bit after the next link edge
    always @(sclk) begin
        #50 out_sr = {out_sr[15:0], sdo};
        if (out_sr === target) n_hit++;
    end
    task automatic settle(input int n);
        repeat (n) @(sclk);
        repeat (4) @(negedge core_clk);
    endtask : settle
    task automatic pop();
        @(negedge core_clk) gr = 1'b1;
        @(negedge core_clk) gr = 1'b0;
    endtask : pop
    // ==========================================
    // Scenarios
    task automatic t_chip_index();
        target = {16'hA004, 1'b1};
        ctl_i.send_frame({`DCL_ID_CHIP_INDEX, 8'h03}, 0, '0, 1'b0);
        settle(80);
        `CHK("address", 5'h03, addr);
        `CHK("forwarded index", 1, n_hit);
    endtask : t_chip_index
    task automatic t_read();
        target = {16'h0003, 1'b0};
        ctl_i.send_frame({`DCL_ID_READ, 8'h00}, 0, '0, 1'b0);
        settle(80);
        `CHK("readback address", 2, n_hit);
    endtask : t_read
    task automatic t_refuse();
        ctl_i.send_frame({`DCL_ID_WR_BCAST, 8'h00}, 3, 48'h1234_5678_9ABC, 1'b1);
        settle(4);
        `CHK("bad check flag", 1, n_ferr);
        `CHK("bad group kept", 1'b0, gv);
        ctl_i.send_frame({8'h55, 8'h09}, 3, 48'h1111_2222_3333, 1'b0);
        settle(4);
        `CHK("unknown group", 1'b0, gv);
        `CHK("unknown address", 5'h03, addr);
    endtask : t_refuse
    task automatic t_buffer();
        for (int i = 1; i <= 3; i++) begin
            ctl_i.send_frame({`DCL_ID_WR_BCAST, 8'h00}, 3, 48'h0101_0202_0303 * i, 1'b0);
        end
        settle(2);
        `CHK("overflow", 1, n_ovf);
        `CHK("first group", {8'hA4, 48'h0101_0202_0303}, gd);
        pop();
        `CHK("second group", {8'hA4, 48'h0202_0404_0606}, gd);
        pop();
        `CHK("drained", 1'b0, gv);
    endtask : t_buffer
    task automatic t_sync();
        ctl_i.send_frame({`DCL_ID_WR_CHAIN, 8'h00}, 3, 48'h4, 1'b0);
        ctl_i.send_frame({`DCL_ID_VSYNC, 8'h00}, 0, '0, 1'b0);
        settle(80);
        `CHK("sync delay", 1'b1, (sync_edge - ctl_i.hdr_edge) inside {69, 70});
        `CHK("no early save", 1'b0, mode.power_save);
    endtask : t_sync
    task automatic t_save();
        ctl_i.send_frame({`DCL_ID_MATRIX_POWER_SAVE_COMMAND, 8'h00}, 0, '0, 1'b0);
        ctl_i.send_frame({`DCL_ID_VSYNC, 8'h00}, 0, '0, 1'b0);
        settle(80);
        `CHK("save entered", 1'b1, mode.power_save);
        `CHK("matrix entered", 1'b1, mode.matrix_save);
        `CHK("save off", 1'b1, mode.outputs_off);
        ctl_i.send_frame({`DCL_ID_WR_GS, 8'h00}, 3, 48'h0001_0002_0003, 1'b0);
        settle(2);
        `CHK("own group", {8'hA5, 48'h0001_0002_0003}, gd);
        `CHK("save left", 1'b0, mode.power_save);
        `CHK("matrix held", 1'b1, mode.matrix_save);
        pop();
        ctl_i.send_frame({`DCL_ID_MATRIX_POWER_SAVE_COMMAND, 8'h00}, 0, '0, 1'b0);
        settle(2);
        `CHK("matrix left", 1'b0, mode.matrix_save);
    endtask : t_save
    task automatic t_fault();
        @(negedge core_clk) hot = 1'b1;
        settle(0);
        `CHK("overtemp off", 1'b1, mode.outputs_off);
        @(negedge core_clk) {hot, rshort} = 2'b01;
        settle(0);
        `CHK("ref short off", 1'b1, mode.outputs_off);
        @(negedge core_clk) rshort = 1'b0;
        settle(0);
        `CHK("resumed", 1'b0, mode.outputs_off);
    endtask : t_fault
    task automatic t_lockout();
        @(negedge core_clk) reset_n = 1'b0;
        settle(0);
        `CHK("lockout address", 5'h00, addr);
        `CHK("lockout output", 1'b1, sdo);
        @(negedge core_clk) reset_n = 1'b1;
    endtask : t_lockout
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    initial begin
        #1_000_000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(negedge core_clk);
        `CHK("reset mode", 3'b000, mode);
        `CHK("reset valid", 1'b0, gv);
        reset_n = 1'b1;
        settle(4);
        t_chip_index();
        t_read();
        t_refuse();
        t_buffer();
        t_sync();
        t_save();
        t_fault();
        t_lockout();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
